// ### rtl/tcs_pkg.sv
// Constants and types shared by the time code cue sequencer
package tcs_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned DEPTH       = 64;
  localparam int unsigned RDEPTH      = 32;
  localparam int unsigned NSLOT       = 8;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CMD      = 8'h04;
  localparam logic [7:0] ADDR_ARG      = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;
  localparam logic [7:0] ADDR_LIST_ARG = 8'h10;
  localparam logic [7:0] ADDR_LIST_OP  = 8'h14;

  // Control and status bit positions
  localparam int unsigned CTRL_PLAY   = 0;
  localparam int unsigned CTRL_AREST  = 1;
  localparam int unsigned CTRL_REC    = 2;
  localparam int unsigned STAT_SERR   = 1;
  localparam int unsigned STAT_OERR   = 2;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [3:0] OP_NONE      = 4'h0;
  localparam logic [3:0] OP_STORE     = 4'h1;
  localparam logic [3:0] OP_END       = 4'h2;
  localparam logic [3:0] OP_LIST      = 4'h3;
  localparam logic [3:0] OP_CUE       = 4'h4;
  localparam logic [3:0] OP_COMMENT   = 4'h5;
  localparam logic [3:0] OP_DELAY     = 4'h6;
  localparam logic [3:0] OP_PULSE     = 4'h7;
  localparam logic [3:0] OP_LATCH_ON  = 4'h8;
  localparam logic [3:0] OP_LATCH_OFF = 4'h9;
  localparam logic [3:0] OP_PORT      = 4'ha;

  // ****************************************
  // Limits and timing
  // ****************************************
  localparam logic [31:0] DELAY_MAX        = 32'h0000270f;
  localparam logic [31:0] COMMENT_MAX      = 32'h000000fa;
  localparam logic [7:0]  PULSE_DEF_TENTHS = 8'h05;
  localparam logic [3:0]  TENTH_CS         = 4'h9;
  localparam int unsigned CLK_MHZ          = 50;
  localparam int unsigned DELAY_UNIT_US    = 10000;
  localparam int unsigned CS_CYCLES_DEF    = DELAY_UNIT_US * CLK_MHZ;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;

  typedef struct packed {
    logic [3:0]  op;
    logic [31:0] arg;
  } tcs_word_s;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SKIP, ST_COPY} tcs_state_e;

endpackage

// ### rtl/tcs_timecode_cue_sequencer.sv
// Time code cue sequencer with AXI4-Lite register access
// ****************************************
// Summary of operation
// - Store command starts a new program; later commands are stored, not run.
// - End command leaves store mode; program length marks the end.
// - List command rewinds the list pointer; program words read out over the bus.
// - Time cue sets the execution time for the commands after it.
// - Comment lines are kept but never executed; host keeps them under 250.
// - Program is kept in storage; a new upload replaces it.
// - With playback on, program runs by itself from incoming time code.
// - With playback off, no program command is executed.
// - Commands between two cues form a run block started by the leading cue.
// - Idle release on: outputs go to rest while time code is absent and record mode is off.
// - Idle release off: outputs hold their state without time code.
// - Record mode: ports 1-4 inputs, ports 5-8 mirror them.
// - Record mode logs up to 16 input changes, each with its time code.
// - When time code stops, the log becomes the stored program at once.
// - Record mode is disabled without the parallel expander.
// - Delay holds back the rest of its block 00.00 to 99.99 seconds.
// - Only a block's first command follows time code; delays pace the rest.
// - New blocks start while older blocks wait out delays.
// - Eight delaying blocks at most; a ninth fails with an overflow error.
// - Malformed commands raise a syntax error; host ends each line properly.
// - Relay pulse closes relay 1-8 for half a second or given tenths.
// ****************************************
`timescale 1ns/1ps
`default_nettype none

module tcs_timecode_cue_sequencer #(
  parameter int unsigned CS_CYCLES = tcs_pkg::CS_CYCLES_DEF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tc_valid,
  input  wire logic        tc_frame,
  input  wire logic [21:0] tc_value,
  input  wire logic        parallel_expander,
  input  wire logic [31:0] port_lo_in,
  output logic [31:0]      port_lo_out,
  output logic             port_lo_oe_n,
  output logic [31:0]      port_hi_out,
  output logic [7:0]       relay_out
);
  import tcs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                   play, arest, rec, store, serr, oerr;
    logic [31:0]            arg;
    logic                   aw_got, w_got, bvalid, rvalid;
    logic [7:0]             awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic [31:0]            rdata;
    logic [1:0]             bresp, rresp;
    tcs_word_s [DEPTH-1:0]  mem;
    logic [6:0]             len, list_ptr;
    tcs_word_s [RDEPTH-1:0] rmem;
    logic [5:0]             rlen, cidx;
    logic [31:0]            rec_last;
    logic                   tc_seen;
    tcs_state_e             st;
    logic [6:0]             main_pc, pc;
    logic                   from_slot;
    logic [NSLOT-1:0]       slot_act;
    logic [NSLOT-1:0][6:0]  slot_pc;
    logic [NSLOT-1:0][13:0] slot_cnt;
    logic [19:0]            cs_cnt;
    logic [3:0]             tenth_cnt;
    logic [7:0]             relay;
    logic [7:0][7:0]        pcnt;
    logic [31:0]            lo, hi;
    logic                   lo_drv;
  } tcs_regs_s;

  tcs_regs_s  q;
  tcs_regs_s  d;
  logic       hcmd;
  tcs_word_s  hw;
  logic       hbad;
  tcs_word_s  cur;
  tcs_word_s  mainw;
  logic       cs_tick;
  logic       tenth_tick;
  logic       rec_on;
  logic       run_ok;
  logic       free;
  logic [2:0] fidx;
  logic       rdy;
  logic [2:0] ridx;
  logic       del_full;

  // ****************************************
  // Command helpers
  // ****************************************
  function automatic logic bad_cmd(input tcs_word_s w);
    logic b;
    b = 1'b0;
    case (w.op)
      OP_STORE, OP_END, OP_LIST, OP_PORT: b = 1'b0;
      OP_PULSE, OP_LATCH_ON, OP_LATCH_OFF: b = (w.arg[3:0] == 4'h0) || (w.arg[3:0] > 4'h8);
      OP_DELAY:   b = w.arg > DELAY_MAX;
      OP_COMMENT: b = w.arg >= COMMENT_MAX;
      OP_CUE:     b = (w.arg[21:17] > 5'h17) || (w.arg[16:11] > 6'h3b) || (w.arg[10:5] > 6'h3b);
      default:    b = 1'b1;
    endcase
    return b;
  endfunction

  // Actions shared by host commands and program playback
  function automatic tcs_regs_s act(input tcs_regs_s s, input tcs_word_s w);
    tcs_regs_s  r;
    logic [2:0] n;
    r = s;
    n = 3'(w.arg[3:0] - 4'h1);
    case (w.op)
      OP_PULSE: begin
        r.relay[n] = 1'b1;
        r.pcnt[n]  = (w.arg[15:8] == 8'h00) ? PULSE_DEF_TENTHS : w.arg[15:8];
      end
      OP_LATCH_ON: begin
        r.relay[n] = 1'b1;
        r.pcnt[n]  = 8'h00;
      end
      OP_LATCH_OFF: begin
        r.relay[n] = 1'b0;
        r.pcnt[n]  = 8'h00;
      end
      OP_PORT: begin
        r.lo     = w.arg;
        r.lo_drv = 1'b1;
      end
      default: r = s;
    endcase
    return r;
  endfunction

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign port_lo_out   = q.lo;
  assign port_lo_oe_n  = !q.lo_drv;
  assign port_hi_out   = q.hi;
  assign relay_out     = q.relay;

  assign cur        = q.mem[q.pc[5:0]];
  assign mainw      = q.mem[q.main_pc[5:0]];
  assign cs_tick    = q.cs_cnt == 20'(CS_CYCLES - 1);
  assign tenth_tick = cs_tick && (q.tenth_cnt == TENTH_CS);
  assign rec_on     = q.rec && parallel_expander && !q.store;
  assign run_ok     = q.play && !q.store && tc_valid;
  assign del_full   = (q.st == ST_RUN) && (q.pc < q.len) && (cur.op == OP_DELAY) && !free;

  always_comb begin
    free = 1'b0;
    fidx = 3'h0;
    rdy  = 1'b0;
    ridx = 3'h0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (!q.slot_act[i]) begin
        free = 1'b1;
        fidx = 3'(i);
      end
      if (q.slot_act[i] && (q.slot_cnt[i] == 14'h0000)) begin
        rdy  = 1'b1;
        ridx = 3'(i);
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d    = q;
    hcmd = 1'b0;
    hw   = '0;
    // Register bus
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      case (q.awaddr)
        ADDR_CTRL: begin
          if (q.wstrb[0]) begin
            d.play  = q.wdata[CTRL_PLAY];
            d.arest = q.wdata[CTRL_AREST];
            d.rec   = q.wdata[CTRL_REC];
          end
        end
        ADDR_ARG: begin
          for (int b = 0; b < 4; b++) begin
            if (q.wstrb[b]) begin
              d.arg[8*b +: 8] = q.wdata[8*b +: 8];
            end
          end
        end
        ADDR_CMD: begin
          hcmd   = q.wstrb[0];
          hw.op  = q.wdata[3:0];
          hw.arg = q.arg;
        end
        ADDR_STATUS: begin
          // Clears come first so that a same-cycle error still sets
          if (q.wstrb[0] && q.wdata[STAT_SERR]) begin
            d.serr = 1'b0;
          end
          if (q.wstrb[0] && q.wdata[STAT_OERR]) begin
            d.oerr = 1'b0;
          end
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_CTRL:     d.rdata = {29'h0, q.rec, q.arest, q.play};
        ADDR_ARG:      d.rdata = q.arg;
        ADDR_CMD:      d.rdata = 32'h0000_0000;
        ADDR_STATUS:   d.rdata = {8'h00, q.slot_act, 1'b0, q.len, 3'h0, rec_on,
                                  q.list_ptr < q.len, q.oerr, q.serr, q.store};
        ADDR_LIST_ARG: d.rdata = (q.list_ptr < q.len) ? q.mem[q.list_ptr[5:0]].arg : 32'h0;
        ADDR_LIST_OP: begin
          if (q.list_ptr < q.len) begin
            d.rdata    = {27'h0, 1'b1, q.mem[q.list_ptr[5:0]].op};
            d.list_ptr = q.list_ptr + 7'h01;
          end
        end
        default: d.rresp = RESP_SLVERR;
      endcase
    end

    // Time base: centisecond for delays, tenth for pulses
    d.cs_cnt = cs_tick ? 20'h00000 : q.cs_cnt + 20'h00001;
    if (cs_tick) begin
      d.tenth_cnt = tenth_tick ? 4'h0 : q.tenth_cnt + 4'h1;
    end
    for (int i = 0; i < 8; i++) begin
      if (tenth_tick && (q.pcnt[i] != 8'h00)) begin
        d.pcnt[i] = q.pcnt[i] - 8'h01;
        if (q.pcnt[i] == 8'h01) begin
          d.relay[i] = 1'b0;
        end
      end
      if (cs_tick && q.slot_act[i] && (q.slot_cnt[i] != 14'h0000)) begin
        d.slot_cnt[i] = q.slot_cnt[i] - 14'h0001;
      end
    end

    // Host commands
    hbad = bad_cmd(hw);
    if (hcmd) begin
      if (hbad) begin
        d.serr = 1'b1;
      end else begin
        case (hw.op)
          OP_STORE: begin
            d.store    = 1'b1;
            d.len      = 7'h00;
            d.main_pc  = 7'h00;
            d.slot_act = '0;
          end
          OP_END:  d.store    = 1'b0;
          OP_LIST: d.list_ptr = 7'h00;
          default: begin
            if (q.store) begin
              if (q.len < 7'(DEPTH)) begin
                d.mem[q.len[5:0]] = hw;
                d.len             = q.len + 7'h01;
              end else begin
                d.serr = 1'b1;
              end
            end else begin
              d = act(d, hw);
            end
          end
        endcase
      end
    end

    // Playback
    unique case (q.st)
      ST_IDLE: begin
        if (run_ok) begin
          if ((q.main_pc < q.len) && (mainw.op != OP_CUE)) begin
            d.main_pc = q.main_pc + 7'h01;
          end else if ((q.main_pc < q.len) && tc_frame && (tc_value >= mainw.arg[21:0])) begin
            d.st        = ST_RUN;
            d.pc        = q.main_pc + 7'h01;
            d.from_slot = 1'b0;
          end else if (rdy) begin
            d.slot_act[ridx] = 1'b0;
            d.pc             = q.slot_pc[ridx];
            d.from_slot      = 1'b1;
            d.st             = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if ((q.pc >= q.len) || (cur.op == OP_CUE)) begin
          if (!q.from_slot) begin
            d.main_pc = q.pc;
          end
          d.st = ST_IDLE;
        end else if (cur.op == OP_DELAY) begin
          if (free) begin
            d.slot_act[fidx] = 1'b1;
            d.slot_pc[fidx]  = q.pc + 7'h01;
            d.slot_cnt[fidx] = cur.arg[13:0];
          end else begin
            d.oerr = 1'b1;
          end
          d.pc = q.pc + 7'h01;
          // A parked main block lets the scan move on to the next cue
          d.st = q.from_slot ? ST_IDLE : ST_SKIP;
        end else begin
          d    = act(d, cur);
          d.pc = q.pc + 7'h01;
        end
      end
      ST_SKIP: begin
        if ((q.pc >= q.len) || (cur.op == OP_CUE)) begin
          d.main_pc = q.pc;
          d.st      = ST_IDLE;
        end else begin
          d.pc = q.pc + 7'h01;
        end
      end
      ST_COPY: begin
        d.mem[q.cidx] = q.rmem[q.cidx[4:0]];
        d.cidx        = q.cidx + 6'h01;
        if (q.cidx == (q.rlen - 6'h01)) begin
          d.len     = 7'(q.rlen);
          d.rlen    = 6'h00;
          d.main_pc = 7'h00;
          d.st      = ST_IDLE;
        end
      end
    endcase
    if (!run_ok && (q.st != ST_COPY)) begin
      d.st = ST_IDLE;
      if (!tc_valid) begin
        // Losing time code ends the pass, so cues may fire again
        d.main_pc  = 7'h00;
        d.slot_act = '0;
      end
    end

    // Record
    if (rec_on) begin
      d.hi     = port_lo_in;
      d.lo_drv = 1'b0;
    end
    if (!tc_valid) begin
      d.rec_last = port_lo_in;
    end
    if (rec_on && tc_valid) begin
      d.tc_seen = 1'b1;
      // A full log drops further changes rather than corrupting it
      if (tc_frame && (port_lo_in != q.rec_last) && (q.rlen <= 6'(RDEPTH - 2))) begin
        d.rmem[q.rlen[4:0]]           = '{op: OP_CUE, arg: {10'h000, tc_value}};
        d.rmem[5'(q.rlen + 6'h01)]    = '{op: OP_PORT, arg: port_lo_in};
        d.rlen                        = q.rlen + 6'h02;
        d.rec_last                    = port_lo_in;
      end
    end
    if (rec_on && q.tc_seen && !tc_valid) begin
      d.tc_seen = 1'b0;
      if (q.rlen != 6'h00) begin
        d.st   = ST_COPY;
        d.cidx = 6'h00;
      end
    end

    // Idle release; with it off, outputs simply hold
    if (q.arest && !tc_valid && !rec_on) begin
      d.relay = 8'h00;
      d.pcnt  = '0;
      d.lo    = 32'h0000_0000;
      d.hi    = 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_host_op(logic [3:0] o);
    hcmd && !hbad && (hw.op == o);
  endsequence

  sequence s_cue_hit;
    (q.st == ST_IDLE) && run_ok && (q.main_pc < q.len) && (mainw.op == OP_CUE)
      && tc_frame && (tc_value >= mainw.arg[21:0]);
  endsequence

  property p_store_open;
    s_host_op(OP_STORE) |=> q.store && (q.len == 7'h00);
  endproperty
  a_store_open: assert property (p_store_open) else $error("store did not open");

  property p_store_line;
    s_host_op(OP_PULSE) ##0 (q.store && (q.len < 7'(DEPTH)))
      |=> (q.len == $past(q.len) + 7'h01) && $stable(q.store);
  endproperty
  a_store_line: assert property (p_store_line) else $error("line not stored");

  property p_end;
    s_host_op(OP_END) |=> !q.store;
  endproperty
  a_end: assert property (p_end) else $error("store mode not left");

  property p_list;
    s_host_op(OP_LIST) |=> (q.list_ptr == 7'h00);
  endproperty
  a_list: assert property (p_list) else $error("list not rewound");

  property p_halt;
    !q.play |=> (q.st != ST_RUN) && (q.st != ST_SKIP);
  endproperty
  a_halt: assert property (p_halt) else $error("playback ran while off");

  property p_cue_fire;
    s_cue_hit |=> (q.st == ST_RUN) && (q.pc == $past(q.main_pc) + 7'h01);
  endproperty
  a_cue_fire: assert property (p_cue_fire) else $error("cue did not fire");

  property p_rest;
    (q.arest && !tc_valid && !rec_on) |=> (relay_out == 8'h00) && (port_hi_out == 32'h0);
  endproperty
  a_rest: assert property (p_rest) else $error("outputs not at rest");

  property p_mirror;
    rec_on |=> (port_hi_out == $past(port_lo_in)) && port_lo_oe_n;
  endproperty
  a_mirror: assert property (p_mirror) else $error("record mirror wrong");

  property p_overflow;
    del_full |=> q.oerr && (q.slot_act == $past(q.slot_act));
  endproperty
  a_overflow: assert property (p_overflow) else $error("ninth delay not refused");

  property p_copy;
    (rec_on && q.tc_seen && !tc_valid && (q.rlen != 6'h00)) |=> (q.st == ST_COPY);
  endproperty
  a_copy: assert property (p_copy) else $error("record not saved");

endmodule

`default_nettype wire

// ### dv/tcs_host_model.sv
// Host model driving AXI4-Lite register accesses
`timescale 1ns/1ps
`default_nettype none
module tcs_host_model (
  input  wire logic  aclk,
  output logic [7:0] awaddr,
  output logic       awvalid,
  input  wire logic  awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic       wvalid,
  input  wire logic  wready,
  input  wire logic  bvalid,
  output logic       bready,
  output logic [7:0] araddr,
  output logic       arvalid,
  input  wire logic  arready,
  input  wire logic  rvalid,
  output logic       rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  // Each task starts on a fresh edge so no signal is assigned twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking testbench for the time code cue sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tcs_pkg::*;
  logic aclk, aresetn, tc_valid, tc_frame, pe, oe_n;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [7:0] awaddr, araddr, relay;
  logic [21:0] tc_value;
  logic [31:0] wdata, rdata, pin, plo, phi;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [3:0] p_op[5] = '{OP_CUE, OP_COMMENT, OP_PULSE, OP_DELAY, OP_LATCH_ON};
  logic [31:0] p_arg[5] = '{32'ha0, 32'hf9, 32'h2, 32'h2, 32'h5};
  int miscompares, comparisons;
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  tcs_timecode_cue_sequencer #(.CS_CYCLES(10)) tcs_timecode_cue_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tc_valid(tc_valid), .tc_frame(tc_frame), .tc_value(tc_value),
    .parallel_expander(pe), .port_lo_in(pin), .port_lo_out(plo),
    .port_lo_oe_n(oe_n), .port_hi_out(phi), .relay_out(relay));
  tcs_host_model tcs_host_model_i (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready));
  task automatic final_report;
    if (rq.size() != 0 || bq.size() != 0) miscompares++;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Notes go on the queue before the access; the monitor settles them
  task automatic rx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    rq.push_back({r, d});
    tcs_host_model_i.rd(a);
  endtask
  task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    bq.push_back(r);
    tcs_host_model_i.wr(a, d);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [31:0] arg);
    wx(ADDR_ARG, arg);
    wx(ADDR_CMD, {28'h0, op});
  endtask
  task automatic frame(input logic [21:0] v);
    @(posedge aclk);
    tc_value <= v;
    tc_frame <= 1'b1;
    @(posedge aclk);
    tc_frame <= 1'b0;
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready && rq.size() > 0) begin
      chk({30'h0, rresp}, {30'h0, rq[0][33:32]});
      chk(rdata, rq[0][31:0]);
      void'(rq.pop_front());
    end
    if (bvalid && bready && bq.size() > 0) chk({30'h0, bresp}, {30'h0, bq.pop_front()});
  end
  initial begin
    tick(20000);
    miscompares++;
    final_report();
  end
  initial begin
    {aresetn, tc_valid, tc_frame, tc_value, pe, pin} = '0;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(32'h38508bca));
    tick(12);
    aresetn <= 1'b1;
    rx(ADDR_STATUS, 32'h0);
    rx(8'h18, 32'h0, RESP_SLVERR);
    wx(8'h1c, 32'h0, RESP_SLVERR);
    cmd(OP_PULSE, 32'h101);
    tick(60);
    chk(relay, 32'h1);
    tick(70);
    chk(relay, 32'h0);
    cmd(OP_PULSE, 32'h9);
    rx(ADDR_STATUS, 32'h2);
    wx(ADDR_STATUS, 32'h2);
    cmd(OP_STORE, 32'h0);
    cmd(OP_DELAY, 32'd10000);
    cmd(OP_COMMENT, 32'd250);
    rx(ADDR_STATUS, 32'h3);
    wx(ADDR_STATUS, 32'h2);
    for (int i = 0; i < 5; i++) cmd(p_op[i], p_arg[i]);
    chk(relay, 32'h0);
    cmd(OP_END, 32'h0);
    cmd(OP_LIST, 32'h0);
    rx(ADDR_STATUS, 32'h508);
    for (int i = 0; i < 5; i++) begin
      rx(ADDR_LIST_ARG, p_arg[i]);
      rx(ADDR_LIST_OP, {28'h1, p_op[i]});
    end
    rx(ADDR_STATUS, 32'h500);
    tc_valid <= 1'b1;
    frame(22'ha1);
    tick(20);
    chk(relay, 32'h0);
    tc_valid <= 1'b0;
    wx(ADDR_CTRL, 32'h1);
    tc_valid <= 1'b1;
    frame(22'h9f);
    tick(5);
    chk(relay, 32'h0);
    frame(22'ha1);
    tick(4);
    chk(relay, 32'h2);
    tick(40);
    chk(relay, 32'h12);
    tc_valid <= 1'b0;
    tick(5);
    chk(relay, 32'h12);
    cmd(OP_PORT, 32'h5a);
    tick(3);
    chk(plo, 32'h5a);
    chk({31'h0, oe_n}, 32'h0);
    wx(ADDR_CTRL, 32'h3);
    tick(3);
    chk(relay, 32'h0);
    chk(plo, 32'h0);
    pe <= 1'b1;
    wx(ADDR_CTRL, 32'h4);
    pin <= $urandom();
    tick(3);
    chk(phi, pin);
    chk({31'h0, oe_n}, 32'h1);
    rx(ADDR_STATUS, 32'h510);
    // One logged change; losing time code saves it
    tc_valid <= 1'b1;
    pin <= pin ^ 32'h0000_0081;
    frame(22'h0001a5);
    tc_valid <= 1'b0;
    tick(5);
    rx(ADDR_STATUS, 32'h210);
    cmd(OP_LIST, 32'h0);
    rx(ADDR_LIST_ARG, 32'h1a5);
    rx(ADDR_LIST_OP, {28'h1, OP_CUE});
    rx(ADDR_LIST_ARG, pin);
    rx(ADDR_LIST_OP, {28'h1, OP_PORT});
    pe <= 1'b0;
    tick(2);
    rx(ADDR_STATUS, 32'h200);
    // Ninth delaying block finds no free slot
    cmd(OP_STORE, 32'h0);
    for (int i = 0; i < 9; i++) begin
      cmd(OP_CUE, 32'h0);
      cmd(OP_DELAY, 32'd200);
    end
    cmd(OP_END, 32'h0);
    wx(ADDR_CTRL, 32'h1);
    tc_valid <= 1'b1;
    repeat (20) frame(22'h1);
    tick(4);
    rx(ADDR_STATUS, 32'hff120c);
    tick(1);
    final_report();
  end
endmodule
`default_nettype wire
